// ---- lbaec_defines.svh ----
`ifndef LBAEC_DEFINES_SVH
`define LBAEC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the control register port
// ----------------------------------------------------------------
`define LBAEC_OFS_STATUS   10'h084
`define LBAEC_OFS_ERRADDR  10'h086
`define LBAEC_OFS_CTRL     10'h087

// ----------------------------------------------------------------
// Control register fields (bit 31 is the leftmost bit)
// ----------------------------------------------------------------
`define LBAEC_CTRL_LSB     27
`define LBAEC_CTRL_RESET   5'h00
`define LBAEC_ORDER_MAX    3'h5

// ----------------------------------------------------------------
// Per-master field offsets inside each group of four status bits
// ----------------------------------------------------------------
`define LBAEC_F_TIMEOUT    2'h0
`define LBAEC_F_RW         2'h1
`define LBAEC_F_FLK        2'h2
`define LBAEC_F_ALK        2'h3
`define LBAEC_STATUS_MASK  32'hffff_ff00
`define LBAEC_STATUS_RESET 32'h0000_0000
`define LBAEC_EAR_RESET    32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LBAEC_TMO_CYCLES   16

`endif

// ---- lbaec_pkg.sv ----
`include "lbaec_defines.svh"

package lbaec_pkg;

    typedef struct packed {
        logic        req;
        logic [1:0]  pri;
        logic        rnw;
        logic [31:0] addr;
    } lbaec_mreq_t;

    typedef struct packed {
        logic        valid;
        logic        rnw;
        logic [2:0]  mid;
        logic [31:0] addr;
    } lbaec_slv_addr_t;

    typedef struct packed {
        logic       busy;
        logic [2:0] mid;
    } lbaec_own_t;

    typedef struct packed {
        lbaec_own_t pri_own;
        lbaec_own_t sec_own;
    } lbaec_dpath_t;

    typedef enum logic [1:0] {
        LBAEC_REQ  = 2'h1,
        LBAEC_XFER = 2'h2
    } lbaec_acyc_t;

    typedef struct packed {
        lbaec_acyc_t     acyc;
        lbaec_slv_addr_t abus;
        logic [7:0]      tcnt;
        logic [2:0]      last_id;
        lbaec_dpath_t    rd;
        lbaec_dpath_t    wr;
        logic [4:0]      ctrl;
        logic [5:0]      rdack;
        logic [5:0]      rcomp;
        logic [31:0]     rdata;
        logic [31:0]     regp_rdata;
        logic            regp_ack;
    } lbaec_core_t;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] ear;
    } lbaec_err_state_t;

    function automatic logic [5:0] lbaec_onehot(input logic [2:0] id);
        return 6'h01 << id;
    endfunction : lbaec_onehot

    // Status bit index of field f of master id, bit 31 leftmost
    function automatic logic [4:0] lbaec_sbit(input logic [2:0] id,
                                              input logic [1:0] f);
        return 5'(31 - 4 * int'(id) - int'(f));
    endfunction : lbaec_sbit

    function automatic lbaec_dpath_t lbaec_take(input lbaec_dpath_t d,
                                                input logic [2:0]   id);
        lbaec_dpath_t r;
        r = d;
        if (!d.pri_own.busy) r.pri_own = '{busy: 1'b1, mid: id};
        else                 r.sec_own = '{busy: 1'b1, mid: id};
        return r;
    endfunction : lbaec_take

    function automatic lbaec_dpath_t lbaec_retire(input lbaec_dpath_t d,
                                                  input logic dack,
                                                  input logic comp);
        lbaec_dpath_t r;
        r = d;
        if (dack && comp) begin
            r.pri_own = d.sec_own;
            r.sec_own = '0;
        end
        return r;
    endfunction : lbaec_retire

endpackage : lbaec_pkg

// ---- lbaec_pick.sv ----
`include "lbaec_defines.svh"
module lbaec_pick (
    input  wire logic [5:0]      req,
    input  wire logic [5:0][1:0] pri,
    input  wire logic            fair_mode,
    input  wire logic [2:0]      order,
    input  wire logic [2:0]      last_id,
    output logic                 win_valid,
    output logic [2:0]           win_id
);
    import lbaec_pkg::*;

    function automatic logic [2:0] lbaec_wrap6(input logic [3:0] v);
        return (v >= 4'h6) ? 3'(v - 4'h6) : v[2:0];
    endfunction : lbaec_wrap6

    logic [1:0] top;
    logic [2:0] start;
    logic [2:0] cand;

    always_comb begin
        top = 2'h0;
        for (int i = 0; i < 6; i++) begin
            if (req[i] && pri[i] > top) top = pri[i];
        end
        // Reserved order codes fall back to the ascending order
        if (fair_mode) begin
            start = lbaec_wrap6({1'b0, last_id} + 4'h1);
        end else if (order > `LBAEC_ORDER_MAX) begin
            start = 3'h0;
        end else begin
            start = order;
        end
        win_valid = |req;
        win_id    = 3'h0;
        cand      = 3'h0;
        // Walk backwards so the first match in rank order wins
        for (int k = 5; k >= 0; k--) begin
            cand = lbaec_wrap6({1'b0, start} + 4'(k));
            if (req[cand] && pri[cand] == top) win_id = cand;
        end
    end

endmodule : lbaec_pick

// ---- lbaec_errcap.sv ----
`include "lbaec_defines.svh"
module lbaec_errcap (
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic                    clk_en,
    input  wire lbaec_pkg::lbaec_slv_addr_t err_ev,
    input  wire logic                    status_wr,
    input  wire logic [31:0]             wdata,
    output logic [31:0]                  status,
    output logic [31:0]                  ear
);
    import lbaec_pkg::*;

    lbaec_err_state_t s;
    lbaec_err_state_t next;
    logic             any_flk;
    logic             any_alk;
    logic             ear_locked;

    always_comb begin
        any_flk = 1'b0;
        any_alk = 1'b0;
        for (int n = 0; n < 6; n++) begin
            any_flk = any_flk | s.status[lbaec_sbit(3'(n), `LBAEC_F_FLK)];
            any_alk = any_alk | s.status[lbaec_sbit(3'(n), `LBAEC_F_ALK)];
        end
        // Address stays held while any address lock and any field lock are both set
        ear_locked = any_alk && any_flk;
        next = s;
        if (status_wr) begin
            next.status = s.status & ~(wdata & `LBAEC_STATUS_MASK);
        end
        // Setting after clearing lets a new error win over a clear
        if (err_ev.valid) begin
            if (!s.status[lbaec_sbit(err_ev.mid, `LBAEC_F_FLK)]) begin
                next.status[lbaec_sbit(err_ev.mid, `LBAEC_F_TIMEOUT)] = 1'b1;
                next.status[lbaec_sbit(err_ev.mid, `LBAEC_F_RW)] =
                    err_ev.rnw;
                next.status[lbaec_sbit(err_ev.mid, `LBAEC_F_FLK)] = 1'b1;
            end
            if (!ear_locked) begin
                next.ear = err_ev.addr;
                next.status[lbaec_sbit(err_ev.mid, `LBAEC_F_ALK)] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{status: `LBAEC_STATUS_RESET, ear: `LBAEC_EAR_RESET};
        end else if (clk_en) begin
            s <= next;
        end
    end

    assign status = s.status;
    assign ear    = s.ear;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n || !clk_en);

    w1c_clear_a: assert property (status_wr && !err_ev.valid |=>
        (status & $past(wdata) & `LBAEC_STATUS_MASK) == 32'h0)
        else $error("written one did not clear status bit");
    ear_hold_a: assert property (err_ev.valid && ear_locked |=>
        $stable(ear))
        else $error("locked error address changed");

endmodule : lbaec_errcap

// ---- lbaec_arbiter.sv ----
`include "lbaec_defines.svh"
// Notes on behaviour
// - Transaction is an address cycle then a data cycle on split paths.
// - Address cycle runs request, transfer, then address acknowledge.
// - Slaves see a master's address only after it is granted.
// - Each beat has a transfer phase and a data acknowledge phase.
// - Address, read and write cycles overlap; owners may differ.
// - A second address per direction is taken as secondary transfer.
// - Requests are accepted while other cycles are in progress.
// - Control bit 0 selects fixed or fair; bits 1:3 give order.
// - Order codes 0 to 5 start ranking at that master; 6, 7 reserved.
// - Error address register holds the address of the timed-out access.
// - Locked error address ignores errors until all field locks clear; here it also unlocks once all address locks clear.
// - Status records timeout per master with read or write kind.
// - A set field lock keeps that master's timeout flag unchanged.
// - Writing one clears a status bit; writing zero leaves it.
// - Master n owns four bits from 4n; bits 24:31 reserved.
// - Read/write status bit is 0 for write, 1 for read.
// - Field lock bit set means that master's fields are locked.
// - Address lock bit set means the address is locked for it.
// - Masters 0 to 5: fetch, data cache, external, PCI, DMA layer, DMA.
// - Two-bit request priority; higher wins before mode and order.
// - Mode and order only decide among equal-priority requests.
module lbaec_arbiter #(
    parameter int TMO_CYCLES = `LBAEC_TMO_CYCLES
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    input  wire logic                     clk_en,
    input  wire lbaec_pkg::lbaec_mreq_t [5:0] mst,
    input  wire logic [5:0][31:0]         mst_wdata,
    output logic [5:0]                    mst_grant,
    output logic [5:0]                    mst_addr_ack,
    output logic [5:0]                    mst_timeout,
    output logic [5:0]                    mst_rd_dack,
    output logic [5:0]                    mst_rd_comp,
    output logic [31:0]                   mst_rd_data,
    output logic [5:0]                    mst_wr_dack,
    output logic [5:0]                    mst_wr_comp,
    output lbaec_pkg::lbaec_slv_addr_t    sl_abus,
    input  wire logic                     sl_addr_ack,
    input  wire logic                     sl_rd_dack,
    input  wire logic                     sl_rd_comp,
    input  wire logic [31:0]              sl_rd_data,
    input  wire logic                     sl_wr_dack,
    input  wire logic                     sl_wr_comp,
    output logic [31:0]                   sl_wr_data,
    input  wire logic [9:0]               regp_addr,
    input  wire logic                     regp_rd,
    input  wire logic                     regp_wr,
    input  wire logic [31:0]              regp_wdata,
    output logic [31:0]                   regp_rdata,
    output logic                          regp_ack,
    output logic                          high_utilization_enable
);
    import lbaec_pkg::*;

    if (TMO_CYCLES < 2 || TMO_CYCLES > 255) begin : g_bad_tmo
        $error("TMO_CYCLES must lie between 2 and 255");
    end

    lbaec_core_t     s;
    lbaec_core_t     next;
    logic [5:0]      req_m;
    logic [5:0][1:0] pri_v;
    logic            win_valid;
    logic [2:0]      win_id;
    logic            ack_now;
    logic            tmo_now;
    lbaec_slv_addr_t err_ev;
    logic [31:0]     status;
    logic [31:0]     ear;
    logic            status_wr;
    logic [5:0]      rd_own_mask;
    logic [5:0]      wr_own_mask;

    // ----------------------------------------------------------------
    // Request masking and arbitration
    // ----------------------------------------------------------------
    // A direction with a secondary already queued cannot take a third
    // address, so its requests wait; the other direction still runs.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pri_v[i] = mst[i].pri;
            req_m[i] = mst[i].req && !(mst[i].rnw ? s.rd.sec_own.busy
                                                  : s.wr.sec_own.busy);
        end
    end

    lbaec_pick u_pick (
        .req       (req_m),
        .pri       (pri_v),
        .fair_mode (s.ctrl[4]),
        .order     (s.ctrl[3:1]),
        .last_id   (s.last_id),
        .win_valid (win_valid),
        .win_id    (win_id)
    );

    // ----------------------------------------------------------------
    // Error capture
    // ----------------------------------------------------------------
    assign ack_now   = s.acyc == LBAEC_XFER && sl_addr_ack;
    assign tmo_now   = s.acyc == LBAEC_XFER && !sl_addr_ack &&
                       s.tcnt == 8'(TMO_CYCLES - 1);
    assign err_ev    = '{valid: tmo_now, rnw: s.abus.rnw,
                         mid: s.abus.mid, addr: s.abus.addr};
    assign status_wr = regp_wr && regp_addr == `LBAEC_OFS_STATUS;

    lbaec_errcap u_errcap (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .err_ev    (err_ev),
        .status_wr (status_wr),
        .wdata     (regp_wdata),
        .status    (status),
        .ear       (ear)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    assign rd_own_mask = lbaec_onehot(s.rd.pri_own.mid);
    assign wr_own_mask = lbaec_onehot(s.wr.pri_own.mid);

    always_comb begin
        next = s;
        // Data paths retire on the completing beat, promoting secondary
        next.rd    = lbaec_retire(s.rd, sl_rd_dack, sl_rd_comp);
        next.wr    = lbaec_retire(s.wr, sl_wr_dack, sl_wr_comp);
        next.rdack = sl_rd_dack ? rd_own_mask : 6'h00;
        next.rcomp = (sl_rd_dack && sl_rd_comp) ? rd_own_mask : 6'h00;
        if (sl_rd_dack) next.rdata = sl_rd_data;
        next.regp_ack   = regp_rd || regp_wr;
        next.regp_rdata = 32'h0;
        if (regp_rd) begin
            if (regp_addr == `LBAEC_OFS_STATUS) begin
                next.regp_rdata = status;
            end else if (regp_addr == `LBAEC_OFS_ERRADDR) begin
                next.regp_rdata = ear;
            end else if (regp_addr == `LBAEC_OFS_CTRL) begin
                next.regp_rdata = {s.ctrl, 27'h0};
            end
        end
        if (regp_wr && regp_addr == `LBAEC_OFS_CTRL) begin
            next.ctrl = regp_wdata[31:`LBAEC_CTRL_LSB];
        end
        case (s.acyc)
            LBAEC_REQ: begin
                if (win_valid) begin
                    next.abus    = '{valid: 1'b1, rnw: mst[win_id].rnw,
                                    mid: win_id,
                                    addr: mst[win_id].addr};
                    next.tcnt    = 8'h00;
                    next.last_id = win_id;
                    next.acyc    = LBAEC_XFER;
                end
            end
            LBAEC_XFER: begin
                if (sl_addr_ack) begin
                    if (s.abus.rnw) begin
                        next.rd = lbaec_take(next.rd, s.abus.mid);
                    end else begin
                        next.wr = lbaec_take(next.wr, s.abus.mid);
                    end
                    next.abus.valid = 1'b0;
                    next.acyc       = LBAEC_REQ;
                end else if (tmo_now) begin
                    next.abus.valid = 1'b0;
                    next.acyc       = LBAEC_REQ;
                end else begin
                    next.tcnt = s.tcnt + 8'h01;
                end
            end
            default: begin
                next.abus.valid = 1'b0;
                next.acyc       = LBAEC_REQ;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{acyc: LBAEC_REQ, default: '0};
        end else if (clk_en) begin
            s <= next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Address and write pulses are gated by the enable so a frozen cycle never repeats one
    assign mst_grant    = s.abus.valid ? lbaec_onehot(s.abus.mid)
                                       : 6'h00;
    assign mst_addr_ack = (ack_now && clk_en) ? lbaec_onehot(s.abus.mid)
                                              : 6'h00;
    assign mst_timeout  = (tmo_now && clk_en) ? lbaec_onehot(s.abus.mid)
                                              : 6'h00;
    assign mst_rd_dack  = s.rdack;
    assign mst_rd_comp  = s.rcomp;
    assign mst_rd_data  = s.rdata;
    // Write acknowledges pass straight through to keep beats aligned
    assign mst_wr_dack  = (sl_wr_dack && clk_en) ? wr_own_mask : 6'h00;
    assign mst_wr_comp  = (sl_wr_dack && sl_wr_comp && clk_en)
                          ? wr_own_mask : 6'h00;
    assign sl_wr_data   = mst_wdata[s.wr.pri_own.mid];
    assign sl_abus      = s.abus;
    assign regp_rdata   = s.regp_rdata;
    assign regp_ack     = s.regp_ack;
    assign high_utilization_enable = s.ctrl[0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n || !clk_en);

    sequence grant_s;
        s.acyc == LBAEC_REQ && win_valid;
    endsequence
    sequence present_s;
        sl_abus.valid && sl_abus.mid == $past(win_id);
    endsequence
    sequence addr_done_s;
        sl_abus.valid && sl_addr_ack;
    endsequence

    grant_present_a: assert property (grant_s |=> present_s)
        else $error("granted master not presented to slaves");
    one_grant_a: assert property ($onehot0(mst_grant))
        else $error("more than one address owner");
    winner_req_a: assert property (grant_s |-> req_m[win_id])
        else $error("grant given to a master not requesting");
    ack_route_a: assert property (addr_done_s |->
        mst_addr_ack == lbaec_onehot(sl_abus.mid))
        else $error("address acknowledge routed wrongly");
    ack_release_a: assert property (addr_done_s |=> !sl_abus.valid)
        else $error("address still presented after acknowledge");
    tmo_bound_a: assert property (s.tcnt < 8'(TMO_CYCLES))
        else $error("address timer ran past its limit");
    tmo_log_a: assert property (tmo_now &&
        !status[lbaec_sbit(s.abus.mid, `LBAEC_F_FLK)] |=>
        status[lbaec_sbit($past(s.abus.mid), `LBAEC_F_TIMEOUT)])
        else $error("timeout not logged");
    rd_route_a: assert property (sl_rd_dack |=>
        mst_rd_dack == $past(rd_own_mask) && mst_rd_data == $past(sl_rd_data))
        else $error("read beat routed wrongly");
    promote_a: assert property (sl_rd_dack && sl_rd_comp &&
        s.rd.sec_own.busy && !ack_now |=> s.rd.pri_own == $past(s.rd.sec_own))
        else $error("secondary read not promoted");

endmodule : lbaec_arbiter

// ---- lbaec_slave_model.sv ----
module lbaec_slave_model #(
    parameter logic [31:0] RD_XOR = 32'h0f0f_0f0f
) (
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire lbaec_pkg::lbaec_slv_addr_t sl_abus,
    input  wire logic                       mute,
    input  wire logic [1:0]                 lat,
    output logic                            sl_addr_ack,
    output logic                            sl_rd_dack,
    output logic                            sl_rd_comp,
    output logic [31:0]                     sl_rd_data,
    output logic                            sl_wr_dack,
    output logic                            sl_wr_comp
);
    timeunit 1ns;
    timeprecision 1ps;
    import lbaec_pkg::*;
    logic [1:0]      cnt;
    logic            beat;
    lbaec_slv_addr_t held;
    // ----------------------------------------------------------------
    // Single-beat slave; mute withholds the acknowledge to force timeouts
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt         <= 2'h0;
            beat        <= 1'b0;
            held        <= '0;
            sl_addr_ack <= 1'b0;
            sl_rd_dack  <= 1'b0;
            sl_rd_comp  <= 1'b0;
            sl_rd_data  <= 32'h0;
            sl_wr_dack  <= 1'b0;
            sl_wr_comp  <= 1'b0;
        end else begin
            sl_rd_dack <= 1'b0;
            sl_rd_comp <= 1'b0;
            sl_wr_dack <= 1'b0;
            sl_wr_comp <= 1'b0;
            // Idle read bus toggles so a stale value never looks valid
            sl_rd_data <= ~sl_rd_data;
            beat       <= sl_addr_ack;
            if (sl_addr_ack) begin
                sl_addr_ack <= 1'b0;
                cnt         <= 2'h0;
            end else if (sl_abus.valid && !mute && cnt == lat) begin
                sl_addr_ack <= 1'b1;
                held        <= sl_abus;
            end else if (sl_abus.valid && !mute) begin
                cnt <= cnt + 2'h1;
            end
            if (beat) begin
                sl_rd_dack <= held.rnw;
                sl_rd_comp <= held.rnw;
                sl_wr_dack <= !held.rnw;
                sl_wr_comp <= !held.rnw;
                sl_rd_data <= held.addr ^ RD_XOR;
            end
        end
    end
endmodule : lbaec_slave_model

// ---- tb_local_bus_arbiter_error_capture.sv ----
`include "lbaec_defines.svh"
module tb_local_bus_arbiter_error_capture;
    timeunit 1ns;
    timeprecision 1ps;
    import lbaec_pkg::*;
    localparam logic [31:0] KX = 32'h0f0f_0f0f;
    logic              core_clk, reset_n, mute, v_q;
    lbaec_mreq_t [5:0] mst;
    logic [5:0][31:0]  mst_wdata;
    logic [5:0]        mst_grant, mst_timeout, mst_rd_dack, mst_wr_dack;
    logic [5:0]        mst_rd_comp, mst_wr_comp;
    logic [31:0]       mst_rd_data, sl_rd_data, sl_wr_data, last_a, ea;
    lbaec_slv_addr_t   sl_abus;
    logic              sl_addr_ack, sl_rd_dack, sl_rd_comp;
    logic              sl_wr_dack, sl_wr_comp, regp_rd, regp_wr, regp_ack;
    logic [9:0]        regp_addr;
    logic [31:0]       regp_wdata, regp_rdata;
    logic [1:0]        lat;
    int                bad_count, checks;
    logic [37:0]       nq[5][$];

    lbaec_arbiter #(.TMO_CYCLES(4)) lbaec_arbiter_i (
        .core_clk, .reset_n, .clk_en(1'b1), .mst, .mst_wdata, .mst_grant,
        .mst_addr_ack(), .mst_timeout, .mst_rd_dack, .mst_rd_comp,
        .mst_rd_data, .mst_wr_dack, .mst_wr_comp, .sl_abus, .sl_addr_ack,
        .sl_rd_dack, .sl_rd_comp, .sl_rd_data, .sl_wr_dack, .sl_wr_comp,
        .sl_wr_data, .regp_addr, .regp_rd, .regp_wr, .regp_wdata,
        .regp_rdata, .regp_ack, .high_utilization_enable()
    );
    lbaec_slave_model #(.RD_XOR(KX)) lbaec_slave_model_i (
        .core_clk, .reset_n, .sl_abus, .mute, .lat, .sl_addr_ack,
        .sl_rd_dack, .sl_rd_comp, .sl_rd_data, .sl_wr_dack, .sl_wr_comp
    );
    // ----------------------------------------------------------------
    // Clock, watchdog and result watcher
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end
    always @(posedge core_clk) begin
        if (reset_n === 1'b1) begin
            if (regp_ack === 1'b1) cmp(0, {6'h00, regp_rdata});
            if (sl_abus.valid === 1'b1 && !v_q)
                cmp(1, {mst_grant, sl_abus.addr});
            if ((|mst_timeout) === 1'b1)
                cmp(2, {mst_timeout, sl_abus.addr});
            if ((|mst_rd_dack) === 1'b1)
                cmp(3, {mst_rd_dack & mst_rd_comp, mst_rd_data});
            if ((|mst_wr_dack) === 1'b1)
                cmp(4, {mst_wr_dack & mst_wr_comp, sl_wr_data});
        end
        v_q = (sl_abus.valid === 1'b1);
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic cmp(input int k, input logic [37:0] got);
        logic [37:0] want;
        want = 'x;
        if (nq[k].size() > 0) want = nq[k].pop_front();
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, want, got);
        end
    endtask : cmp
    task automatic reg_op(input logic w, input logic [9:0] a,
                          input logic [31:0] d, input logic [31:0] e);
        nq[0].push_back({6'h00, e});
        @(negedge core_clk);
        regp_addr  = a;
        regp_wdata = d;
        regp_wr    = w;
        regp_rd    = !w;
        @(negedge core_clk);
        regp_wr = 1'b0;
        regp_rd = 1'b0;
        @(negedge core_clk);
    endtask : reg_op
    // Masters in who request together; w must win; tmo expects a timeout
    task automatic race(input logic [5:0] who, input logic [5:0][1:0] pr,
                        input logic rnw, input int w, input logic tmo);
        logic [5:0] oh;
        oh = 6'h01 << w;
        @(negedge core_clk);
        for (int m = 0; m < 6; m++) begin
            mst[m] = '{req: who[m], pri: pr[m], rnw: rnw, addr: $urandom};
            mst_wdata[m] = $urandom;
        end
        last_a = mst[w].addr;
        nq[1].push_back({oh, last_a});
        if (tmo) nq[2].push_back({oh, last_a});
        else if (rnw) nq[3].push_back({oh, last_a ^ KX});
        else nq[4].push_back({oh, mst_wdata[w]});
        @(negedge core_clk);
        for (int m = 0; m < 6; m++) mst[m].req = 1'b0;
        for (int n = 0; n < 60 && (nq[1].size() + nq[2].size()
             + nq[3].size() + nq[4].size()) != 0; n++) @(negedge core_clk);
    endtask : race
    task automatic end_of_test;
        for (int k = 0; k < 5; k++) bad_count += nq[k].size();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        mute = 1'b0;
        lat = 2'h0;
        v_q = 1'b0;
        mst = '0;
        mst_wdata = '0;
        {regp_addr, regp_rd, regp_wr, regp_wdata} = '0;
        void'($urandom(72));
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        reg_op(1'b0, `LBAEC_OFS_STATUS, 32'h0, 32'h0);
        reg_op(1'b0, `LBAEC_OFS_ERRADDR, 32'h0, 32'h0);
        reg_op(1'b0, `LBAEC_OFS_CTRL, 32'h0, 32'h0);
        reg_op(1'b0, 10'h085, 32'h0, 32'h0);
        $display("test reset ended");
        ea = $urandom;
        reg_op(1'b1, `LBAEC_OFS_CTRL, ea, 32'h0);
        reg_op(1'b0, `LBAEC_OFS_CTRL, 32'h0, ea & 32'hf800_0000);
        $display("test control ended");
        for (int o = 0; o < 8; o++) begin
            reg_op(1'b1, `LBAEC_OFS_CTRL, {1'b0, 3'(o), 28'h0}, 32'h0);
            lat = 2'($urandom_range(1));
            race(6'h3f, {6{2'h2}}, 1'b1, (o > 5) ? 0 : o, 1'b0);
        end
        reg_op(1'b1, `LBAEC_OFS_CTRL, 32'h0, 32'h0);
        race(6'h3f, {2'h3, 10'h24a}, 1'b0, 5, 1'b0);
        reg_op(1'b1, `LBAEC_OFS_CTRL, 32'hb000_0000, 32'h0);
        for (int i = 0; i < 2; i++) race(6'h3f, {6{2'h1}}, 1'b1, i, 1'b0);
        $display("test arbitration ended");
        mute = 1'b1;
        race(6'h04, '0, 1'b1, 2, 1'b1);
        ea = last_a;
        reg_op(1'b0, `LBAEC_OFS_STATUS, 32'h0, 32'h00f0_0000);
        reg_op(1'b0, `LBAEC_OFS_ERRADDR, 32'h0, ea);
        race(6'h10, '0, 1'b0, 4, 1'b1);
        reg_op(1'b0, `LBAEC_OFS_STATUS, 32'h0, 32'h00f0_a000);
        reg_op(1'b0, `LBAEC_OFS_ERRADDR, 32'h0, ea);
        reg_op(1'b1, `LBAEC_OFS_STATUS, 32'h00f0_0000, 32'h0);
        reg_op(1'b0, `LBAEC_OFS_STATUS, 32'h0, 32'h0000_a000);
        race(6'h10, '0, 1'b1, 4, 1'b1);
        reg_op(1'b0, `LBAEC_OFS_STATUS, 32'h0, 32'h0000_b000);
        reg_op(1'b0, `LBAEC_OFS_ERRADDR, 32'h0, last_a);
        reg_op(1'b1, `LBAEC_OFS_STATUS, 32'hffff_ffff, 32'h0);
        reg_op(1'b0, `LBAEC_OFS_STATUS, 32'h0, 32'h0);
        mute = 1'b0;
        $display("test error capture ended");
        end_of_test();
    end
endmodule : tb_local_bus_arbiter_error_capture
